/* File: bench/accl_analog_model.sv */
`include "accl_cfg.svh"
`default_nettype none
module accl_analog_model (
  input wire logic clk,
  input wire logic slow,
  input wire logic [`ACCL_LVL_W-1:0] pos_tgt,
  input wire logic [`ACCL_LVL_W-1:0] neg_tgt,
  input wire logic [8*`ACCL_LVL_W-1:0] chan_tgt,
  output logic [`ACCL_LVL_W-1:0] pos_lvl,
  output logic [`ACCL_LVL_W-1:0] neg_lvl,
  output logic [8*`ACCL_LVL_W-1:0] chan_lvl
);
  timeunit 1ns;
  timeprecision 1ps;
  // slow mode slews the positive pin one code per clock, like a filtered
  // source, so the result crosses late and exactly once
  always_ff @(posedge clk)
  begin
    neg_lvl <= neg_tgt;
    chan_lvl <= chan_tgt;
    if (!slow || pos_lvl === pos_tgt)
      pos_lvl <= pos_tgt;
    else if (pos_lvl < pos_tgt)
      pos_lvl <= pos_lvl + 1'b1;
    else
      pos_lvl <= pos_lvl - 1'b1;
  end
endmodule
`default_nettype wire

/* File: bench/tb_top.sv */
`include "accl_cfg.svh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int W = `ACCL_LVL_W;
  localparam int LIMIT = 20000;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata, cnt;
  logic io = 1'b0, we = 1'b0, re = 1'b0, ce = 1'b1;
  logic [W-1:0] pos_t = 10'h064, neg_t = 10'h0C8, bg = 10'h00A;
  logic [W-1:0] pos_l, neg_l, p, n;
  logic [8*W-1:0] chan_t = '0, chan_l, ch;
  logic [2:0] csel = 3'h0;
  logic conv_en = 0, at_en = 0, gie = 0, ack = 0, slow = 0;
  logic [7:2] tflags = '0;
  logic [1:0] pin_in = '0, pin_rd, buf_en;
  logic irq, cap, start, pwr, cur, ef, e;
  int num_errors = 0, samples_checked = 0, cyc = 0, seed = 48896, c;

  accl_analog_model accl_analog_model_inst (.clk(clk), .slow(slow),
    .pos_tgt(pos_t), .neg_tgt(neg_t), .chan_tgt(chan_t),
    .pos_lvl(pos_l), .neg_lvl(neg_l), .chan_lvl(chan_l));

  accl_top accl_top_inst (.CLK(clk), .RST_N(rst_n), .CE(ce),
    .BUS_ADDR(addr), .BUS_IO_SPACE(io), .BUS_WE(we), .BUS_RE(re),
    .BUS_WDATA(wdata), .BUS_RDATA(rdata), .POSITIVE_INPUT_PIN(pos_l),
    .NEGATIVE_INPUT_PIN(neg_l), .BANDGAP_LEVEL(bg), .CHANNEL_PIN(chan_l),
    .CHANNEL_SELECT(csel), .CONVERTER_ENABLE(conv_en),
    .AUTO_TRIGGER_ENABLE(at_en), .GLOBAL_IRQ_ENABLE(gie),
    .IRQ_TAKEN(ack), .TRIGGER_FLAGS(tflags), .PORT_PIN_IN(pin_in),
    .PORT_PIN_READ(pin_rd), .DIGITAL_BUF_EN(buf_en), .COMPARE_IRQ(irq),
    .CAPTURE_INPUT(cap), .CONVERSION_START(start),
    .COMPARATOR_POWERED(pwr));

  // ********
  // helpers
  // ********
  always #2.5 clk = ~clk;

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == LIMIT)
    begin
      num_errors++;
      $display("mismatch at %0t: run did not finish", $time);
      summarize();
    end
  end

  function automatic logic hit(input logic [1:0] m, input logic o, x);
    case (m)
      2'h0: return o != x;
      2'h2: return o & !x;
      2'h3: return !o & x;
      default: return 1'b0;
    endcase
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic s, input logic [7:0] a, d);
    @(posedge clk);
    io <= s;
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask

  task automatic rdc(input logic s, input logic [7:0] a, exp);
    @(posedge clk);
    io <= s;
    addr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1 chk(rdata, exp);
  endtask

  task automatic starts(input int k);
    cnt = 8'h00;
    repeat (k)
    begin
      @(posedge clk);
      #1 cnt = cnt + start;
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ********
  // tests
  // ********
  initial
  begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rdc(0, 8'h50, 8'h00);
    rdc(0, 8'h7B, 8'h00);
    rdc(0, 8'h7F, 8'h00);
    chk(buf_en, 8'h03);
    wr(1, 8'h30, 8'h5F);
    rdc(0, 8'h50, 8'h4F);
    rdc(0, 8'h51, 8'h00);
    rdc(1, 8'h5B, 8'h00);
    wr(0, 8'h7B, 8'hFF);
    rdc(0, 8'h7B, 8'h47);
    pin_in <= 2'h3;
    wr(0, 8'h7F, 8'hFF);
    repeat (4) @(posedge clk);
    rdc(0, 8'h7F, 8'h03);
    chk(pin_rd, 8'h00);
    chk(buf_en, 8'h00);
    wr(0, 8'h7F, 8'h01);
    repeat (4) @(posedge clk);
    #1 chk(pin_rd, 8'h02);
    chk(buf_en, 8'h02);
    wr(0, 8'h7B, 8'h00);
    $display("done registers");
    // irq kept masked while the mode changes
    cur = 0;
    for (int m = 0; m < 4; m++)
    begin
      wr(0, 8'h50, 8'h10 | m[7:0]);
      wr(0, 8'h50, 8'h18 | m[7:0]);
      ef = 0;
      repeat (10)
      begin
        {p, n} = 20'($random(seed));
        pos_t <= p;
        neg_t <= n;
        gie <= p[3];
        repeat (6) @(posedge clk);
        ef = ef | hit(m[1:0], cur, p > n);
        cur = p > n;
        #1 chk(irq, ef & p[3]);
        rdc(0, 8'h50, {2'h0, cur, ef, 2'h2, m[1:0]});
        c = $random(seed) & 3;
        if (c == 0)
        begin
          ack <= 1'b1;
          @(posedge clk);
          ack <= 1'b0;
          ef = 0;
        end
        else if (c == 1)
        begin
          wr(0, 8'h50, 8'h18 | m[7:0]);
          ef = 0;
        end
        else
          wr(0, 8'h50, 8'h08 | m[7:0]);
      end
    end
    $display("done edges");
    wr(0, 8'h50, 8'h19);
    wr(0, 8'h7B, 8'h40);
    gie <= 1'b1;
    for (int k = 0; k < 24; k++)
    begin
      {p, n} = 20'($random(seed));
      ch = 80'({$random(seed), $random(seed), $random(seed)});
      pos_t <= p;
      neg_t <= n;
      chan_t <= ch;
      csel <= k[2:0];
      conv_en <= k[3];
      e = p > (k[3] ? n : ch[k[2:0]*W +: W]);
      repeat (5) @(posedge clk);
      rdc(0, 8'h50, {2'h0, e, 5'h09});
      chk(irq, 8'h00);
    end
    $display("done mux");
    conv_en <= 0;
    wr(0, 8'h7B, 8'h00);
    neg_t <= 10'h200;
    pos_t <= 10'h100;
    bg <= 10'h300;
    wr(0, 8'h50, 8'h41);
    repeat (4) @(posedge clk);
    rdc(0, 8'h50, 8'h61);
    wr(0, 8'h50, 8'h81);
    repeat (4) @(posedge clk);
    rdc(0, 8'h50, 8'h81);
    chk(pwr, 8'h00);
    slow <= 1'b1;
    wr(0, 8'h50, 8'h05);
    pos_t <= 10'h2C0;
    repeat (100) @(posedge clk);
    chk(cap, 8'h00);
    repeat (400) @(posedge clk);
    chk(cap, 8'h01);
    chk(pwr, 8'h01);
    wr(0, 8'h50, 8'h01);
    repeat (3) @(posedge clk);
    chk(cap, 8'h00);
    slow <= 1'b0;
    pos_t <= 10'h100;
    $display("done analog");
    repeat (5) @(posedge clk);
    wr(0, 8'h50, 8'h13);
    conv_en <= 1;
    at_en <= 1;
    for (int s = 2; s < 8; s++)
    begin
      wr(0, 8'h7B, s[7:0]);
      tflags[s] <= 1'b1;
      starts(5);
      chk(cnt, 8'h01);
      tflags[s] <= 1'b0;
    end
    tflags <= 6'h02;
    starts(4);
    chk(cnt, 8'h00);
    wr(0, 8'h7B, 8'h03);
    starts(4);
    chk(cnt, 8'h01);
    wr(0, 8'h7B, 8'h00);
    tflags <= 6'h3F;
    starts(4);
    chk(cnt, 8'h00);
    at_en <= 0;
    wr(0, 8'h7B, 8'h02);
    starts(4);
    chk(cnt, 8'h00);
    at_en <= 1;
    tflags <= 6'h00;
    wr(0, 8'h7B, 8'h01);
    pos_t <= 10'h300;
    starts(10);
    chk(cnt, 8'h01);
    $display("done triggers");
    // a write while the enable is low must leave the registers untouched
    ce <= 1'b0;
    wr(0, 8'h7B, 8'h45);
    ce <= 1'b1;
    rdc(0, 8'h7B, 8'h01);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rdc(0, 8'h7B, 8'h00);
    rdc(0, 8'h7F, 8'h00);
    chk(buf_en, 8'h03);
    $display("done freeze and reset");
    summarize();
  end
endmodule
`default_nettype wire

/* File: common/accl_cfg.svh */
`ifndef ACCL_CFG_SVH
`define ACCL_CFG_SVH

// data-space offsets of the three registers
`define ACCL_CMP_CTRL_OFS 8'h50
`define ACCL_CONV_B_OFS 8'h7B
`define ACCL_DIG_DIS_OFS 8'h7F
// short i/o space sits this far below data space
`define ACCL_IO_DELTA 8'h20
`define ACCL_IO_LIMIT 8'h40

// comparator control/status fields
`define ACCL_BIT_PWR_OFF 7
`define ACCL_BIT_BG_SEL 6
`define ACCL_BIT_RESULT 5
`define ACCL_BIT_FLAG 4
`define ACCL_BIT_IRQ_EN 3
`define ACCL_BIT_CAP_RT 2
`define ACCL_BIT_MODE_HI 1

// converter control b fields
`define ACCL_BIT_MUX_EN 6
`define ACCL_BIT_SRC_HI 2

// digital input disable fields
`define ACCL_BIT_POS_OFF 0
`define ACCL_BIT_NEG_OFF 1

// reset values
`define ACCL_CONV_B_RST 8'h00
`define ACCL_DIG_DIS_RST 8'h00

// analog levels are carried as unsigned codes of this width
`define ACCL_LVL_W 10

`endif

/* File: common/accl_pkg.sv */
`default_nettype none
package accl_pkg;

  typedef enum logic [1:0] {
    ACCL_EDGE_TOGGLE = 2'b00,
    ACCL_EDGE_RESV = 2'b01,
    ACCL_EDGE_FALL = 2'b10,
    ACCL_EDGE_RISE = 2'b11
  } accl_edge_t;

  typedef enum logic [2:0] {
    ACCL_TRIG_FREE = 3'b000,
    ACCL_TRIG_CMP = 3'b001,
    ACCL_TRIG_EXT0 = 3'b010,
    ACCL_TRIG_T0CMPA = 3'b011,
    ACCL_TRIG_T0OVF = 3'b100,
    ACCL_TRIG_T1CMPB = 3'b101,
    ACCL_TRIG_T1OVF = 3'b110,
    ACCL_TRIG_T1CAPT = 3'b111
  } accl_trig_t;

endpackage
`default_nettype wire

/* File: rtl/accl_sync.sv */
`default_nettype none
module accl_sync #(
  parameter int W = 1
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic [W-1:0] D,
  output logic [W-1:0] Q
);
  logic [W-1:0] stage1;

  // stage1 feeds only the second flop
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      stage1 <= '0;
      Q <= '0;
    end
    else if (CE)
    begin
      stage1 <= D;
      Q <= stage1;
    end
  end
endmodule
`default_nettype wire

/* File: rtl/accl_top.sv */
// Behaviour
// - raw result is high when selected positive level exceeds selected negative
// - raw result passes a two-flop synchronizer, readable with 2 cycles delay
// - mux enable set and converter off: channel_select picks channel pin 0..7
// - mux enable clear or converter on: negative pin drives negative input
// - bandgap select replaces the positive pin by the bandgap reference
// - power-off bit switches the comparator off at any moment
// - event flag sets on the edge chosen by irq_edge_mode
// - flag clears on vector acknowledge or on writing one; zero does nothing
// - interrupt request is flag and enable and global enable
// - mode 00 toggle, 01 reserved, 10 falling, 11 rising
// - route enable feeds the result to timer capture; otherwise no path
// - auto-trigger source decodes eight sources, only with auto-trigger enabled
// - rising edge of selected source flag starts a conversion, also on switch
// - free-running selection never creates a trigger event
// - pin digital-off bits disable buffers and force pin reads to zero
// - control register answers at 0x50 data space and 0x30 i/o space
// - auto_trigger_enable gates whether the source is honoured
// - converter_enable switches converter on and blocks lending the mux
`include "accl_cfg.svh"
`default_nettype none
module accl_top (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic [7:0] BUS_ADDR,
  input wire logic BUS_IO_SPACE,
  input wire logic BUS_WE,
  input wire logic BUS_RE,
  input wire logic [7:0] BUS_WDATA,
  output logic [7:0] BUS_RDATA,
  input wire logic [`ACCL_LVL_W-1:0] POSITIVE_INPUT_PIN,
  input wire logic [`ACCL_LVL_W-1:0] NEGATIVE_INPUT_PIN,
  input wire logic [`ACCL_LVL_W-1:0] BANDGAP_LEVEL,
  input wire logic [8*`ACCL_LVL_W-1:0] CHANNEL_PIN,
  input wire logic [2:0] CHANNEL_SELECT,
  input wire logic CONVERTER_ENABLE,
  input wire logic AUTO_TRIGGER_ENABLE,
  input wire logic GLOBAL_IRQ_ENABLE,
  input wire logic IRQ_TAKEN,
  input wire logic [7:2] TRIGGER_FLAGS,
  input wire logic [1:0] PORT_PIN_IN,
  output logic [1:0] PORT_PIN_READ,
  output logic [1:0] DIGITAL_BUF_EN,
  output logic COMPARE_IRQ,
  output logic CAPTURE_INPUT,
  output logic CONVERSION_START,
  output logic COMPARATOR_POWERED
);

  // ************************************************************
  // register state
  // ************************************************************
  logic power_off;
  logic bg_select;
  logic event_flag;
  logic irq_en;
  logic cap_route;
  accl_pkg::accl_edge_t edge_mode;
  logic mux_en;
  accl_pkg::accl_trig_t trig_src;
  logic pos_off;
  logic neg_off;

  logic [7:0] eff_addr;
  logic addr_ok;
  logic hit_cmp;
  logic hit_conv;
  logic hit_dis;
  logic wr_cmp;

  function automatic logic [7:0] decode_addr(input logic [7:0] a,
                                             input logic io);
    logic [7:0] r;
    r = io ? 8'(a + `ACCL_IO_DELTA) : a;
    return r;
  endfunction

  always_comb
  begin
    eff_addr = decode_addr(BUS_ADDR, BUS_IO_SPACE);
    addr_ok = !BUS_IO_SPACE || (BUS_ADDR < `ACCL_IO_LIMIT);
    hit_cmp = addr_ok && (eff_addr == `ACCL_CMP_CTRL_OFS);
    hit_conv = addr_ok && (eff_addr == `ACCL_CONV_B_OFS);
    hit_dis = addr_ok && (eff_addr == `ACCL_DIG_DIS_OFS);
    wr_cmp = BUS_WE && hit_cmp;
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      power_off <= 1'b0;
      bg_select <= 1'b0;
      irq_en <= 1'b0;
      cap_route <= 1'b0;
      edge_mode <= accl_pkg::ACCL_EDGE_TOGGLE;
    end
    else if (CE && wr_cmp)
    begin
      power_off <= BUS_WDATA[`ACCL_BIT_PWR_OFF];
      bg_select <= BUS_WDATA[`ACCL_BIT_BG_SEL];
      irq_en <= BUS_WDATA[`ACCL_BIT_IRQ_EN];
      cap_route <= BUS_WDATA[`ACCL_BIT_CAP_RT];
      edge_mode <= accl_pkg::accl_edge_t'(
        BUS_WDATA[`ACCL_BIT_MODE_HI -: 2]);
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      mux_en <= 1'(`ACCL_CONV_B_RST >> `ACCL_BIT_MUX_EN);
      trig_src <= accl_pkg::ACCL_TRIG_FREE;
    end
    else if (CE && BUS_WE && hit_conv)
    begin
      mux_en <= BUS_WDATA[`ACCL_BIT_MUX_EN];
      trig_src <= accl_pkg::accl_trig_t'(BUS_WDATA[`ACCL_BIT_SRC_HI -: 3]);
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      pos_off <= 1'(`ACCL_DIG_DIS_RST >> `ACCL_BIT_POS_OFF);
      neg_off <= 1'(`ACCL_DIG_DIS_RST >> `ACCL_BIT_NEG_OFF);
    end
    else if (CE && BUS_WE && hit_dis)
    begin
      pos_off <= BUS_WDATA[`ACCL_BIT_POS_OFF];
      neg_off <= BUS_WDATA[`ACCL_BIT_NEG_OFF];
    end
  end

  // ************************************************************
  // input selection and comparison
  // ************************************************************
  logic [`ACCL_LVL_W-1:0] pos_level;
  logic [`ACCL_LVL_W-1:0] neg_level;
  logic lend_mux;
  logic raw_cmp;
  logic compare_result;

  always_comb
  begin
    lend_mux = mux_en && !CONVERTER_ENABLE;
    pos_level = bg_select ? BANDGAP_LEVEL : POSITIVE_INPUT_PIN;
    if (lend_mux)
      neg_level = CHANNEL_PIN[CHANNEL_SELECT*`ACCL_LVL_W +:
                              `ACCL_LVL_W];
    else
      neg_level = NEGATIVE_INPUT_PIN;
    // a powered-down comparator holds its output low
    raw_cmp = !power_off && (pos_level > neg_level);
  end

  assign COMPARATOR_POWERED = !power_off;

  // the analog output is asynchronous to CLK
  accl_sync #(.W(1)) u_res_sync (
    .CLK(CLK),
    .RST_N(RST_N),
    .CE(CE),
    .D(raw_cmp),
    .Q(compare_result)
  );

  // ************************************************************
  // edge detection and event flag
  // ************************************************************
  logic result_prev;
  logic rise;
  logic fall;
  logic set_evt;
  logic clr_evt;

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
      result_prev <= 1'b0;
    else if (CE)
      result_prev <= compare_result;
  end

  always_comb
  begin
    rise = compare_result && !result_prev;
    fall = !compare_result && result_prev;
    case (edge_mode)
      accl_pkg::ACCL_EDGE_TOGGLE: set_evt = rise || fall;
      accl_pkg::ACCL_EDGE_FALL: set_evt = fall;
      accl_pkg::ACCL_EDGE_RISE: set_evt = rise;
      accl_pkg::ACCL_EDGE_RESV: set_evt = 1'b0;
      default: set_evt = 1'b0;
    endcase
    clr_evt = IRQ_TAKEN || (wr_cmp && BUS_WDATA[`ACCL_BIT_FLAG]);
  end

  // a new event in the clearing cycle wins over the clear
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
      event_flag <= 1'b0;
    else if (CE)
    begin
      if (set_evt)
        event_flag <= 1'b1;
      else if (clr_evt)
        event_flag <= 1'b0;
    end
  end

  assign COMPARE_IRQ = event_flag && irq_en && GLOBAL_IRQ_ENABLE;

  // ************************************************************
  // capture routing
  // ************************************************************
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
      CAPTURE_INPUT <= 1'b0;
    else if (CE)
      CAPTURE_INPUT <= cap_route && compare_result;
  end

  // ************************************************************
  // auto-trigger source
  // ************************************************************
  logic trig_sel;
  logic trig_prev;

  always_comb
  begin
    case (trig_src)
      accl_pkg::ACCL_TRIG_FREE: trig_sel = 1'b0;
      accl_pkg::ACCL_TRIG_CMP: trig_sel = event_flag;
      default: trig_sel = TRIGGER_FLAGS[trig_src];
    endcase
  end

  // the previous value is kept across source changes, so switching
  // from a clear source to a set one looks like a rising edge
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      trig_prev <= 1'b0;
      CONVERSION_START <= 1'b0;
    end
    else if (CE)
    begin
      trig_prev <= trig_sel;
      CONVERSION_START <= AUTO_TRIGGER_ENABLE && CONVERTER_ENABLE &&
                          trig_sel && !trig_prev;
    end
  end

  // ************************************************************
  // digital input disable
  // ************************************************************
  logic [1:0] pin_sync;

  accl_sync #(.W(2)) u_pin_sync (
    .CLK(CLK),
    .RST_N(RST_N),
    .CE(CE),
    .D(PORT_PIN_IN),
    .Q(pin_sync)
  );

  assign DIGITAL_BUF_EN = {!neg_off, !pos_off};

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
      PORT_PIN_READ <= 2'b00;
    else if (CE)
      PORT_PIN_READ <= pin_sync & {!neg_off, !pos_off};
  end

  // ************************************************************
  // read path
  // ************************************************************
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
      BUS_RDATA <= 8'h00;
    else if (CE && BUS_RE)
    begin
      if (hit_cmp)
        BUS_RDATA <= {power_off, bg_select, compare_result, event_flag,
                      irq_en, cap_route, edge_mode};
      else if (hit_conv)
        BUS_RDATA <= {1'b0, mux_en, 3'b000, trig_src};
      else if (hit_dis)
        BUS_RDATA <= {6'b00_0000, neg_off, pos_off};
      else
        BUS_RDATA <= 8'h00;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  sequence s_raw_high;
    (CE && raw_cmp)[*3];
  endsequence

  sequence s_raw_low;
    (CE && !raw_cmp)[*3];
  endsequence

  sequence s_rise_seen;
    CE && rise && edge_mode == accl_pkg::ACCL_EDGE_RISE;
  endsequence

  a_result_latency_hi: assert property (s_raw_high |-> compare_result)
    else $error("result not high two cycles after raw");
  a_result_latency_lo: assert property (s_raw_low |-> !compare_result)
    else $error("result not low two cycles after raw");
  a_raw_compare: assert property (power_off |-> !raw_cmp)
    else $error("powered-down comparator output high");
  a_neg_mux_pin: assert property (
    (!mux_en || CONVERTER_ENABLE) |-> neg_level == NEGATIVE_INPUT_PIN)
    else $error("negative pin not selected");
  a_flag_on_rise: assert property (s_rise_seen |=> event_flag)
    else $error("rising edge did not set flag");
  a_flag_clear: assert property (
    CE && IRQ_TAKEN && !set_evt |=> !event_flag)
    else $error("acknowledge did not clear flag");
  a_flag_write_zero: assert property (
    CE && event_flag && wr_cmp && !BUS_WDATA[`ACCL_BIT_FLAG] &&
    !IRQ_TAKEN |=> event_flag)
    else $error("writing zero cleared flag");
  a_irq_gate: assert property (
    COMPARE_IRQ |-> event_flag && irq_en && GLOBAL_IRQ_ENABLE)
    else $error("irq without flag and enables");
  a_reserved_quiet: assert property (
    CE && edge_mode == accl_pkg::ACCL_EDGE_RESV && !event_flag &&
    $stable(edge_mode) |=> !event_flag)
    else $error("reserved mode set flag");
  a_capture_off: assert property (
    CE && !cap_route |=> !CAPTURE_INPUT)
    else $error("capture path active while not routed");
  a_free_no_trig: assert property (
    CE && trig_src == accl_pkg::ACCL_TRIG_FREE |=> !CONVERSION_START)
    else $error("free-running source produced a trigger");
  a_trig_edge: assert property (
    CE && AUTO_TRIGGER_ENABLE && CONVERTER_ENABLE && trig_sel &&
    !trig_prev |=> CONVERSION_START)
    else $error("source edge did not start conversion");
  a_trig_gated: assert property (
    CE && !AUTO_TRIGGER_ENABLE |=> !CONVERSION_START)
    else $error("trigger while auto-trigger disabled");
  a_pin_off_zero: assert property (
    CE && pos_off |=> !PORT_PIN_READ[0])
    else $error("disabled pin read not zero");

endmodule
`default_nettype wire
